// File: include/zcb_consts.vh
// Constants for the zero-compare branch-and-link unit
// Function
// - Opcode 000110 split by source fields
// - Opcode 000111 split by source fields
// - Opcodes 001000, 011000 give equal/unequal links
// - Signed forms test below, at most, at least, above
// - Equality forms test zero or nonzero
// - Compact link value is branch plus four
// - Compact forms always write the link
// - Target: next address plus shifted displacement
// - Taken compact branch suppresses next instruction
// - Control transfer in open forbidden slot faults
// - Control transfers: branches, jumps, returns, wait, pause
// - Likely link value is branch plus eight
// - Likely taken on clear sign bit
// - Untaken likely form nullifies its slot
// - Likely form absent in release 6 mode
// - Decode register fields beside the opcode
// - Delayed link from register zero always taken
`ifndef ZCB_CONSTS_VH
`define ZCB_CONSTS_VH

// Instruction field positions
`define ZCB_OP_HI 31
`define ZCB_OP_LO 26
`define ZCB_RS_HI 25
`define ZCB_RS_LO 21
`define ZCB_RT_HI 20
`define ZCB_RT_LO 16
`define ZCB_IMM_HI 15
`define ZCB_IMM_LO 0
`define ZCB_FN_HI 5
`define ZCB_FN_LO 0
`define ZCB_CO_BIT 25
`define ZCB_SIGN_BIT 31

// Primary opcodes
`define ZCB_OP_SPECIAL 6'h00
`define ZCB_OP_REGIMM 6'h01
`define ZCB_OP_JUMP 6'h02
`define ZCB_OP_ABS_CALL 6'h03
`define ZCB_OP_BR_EQ 6'h04
`define ZCB_OP_BR_NE 6'h05
`define ZCB_OP_LE_GROUP 6'h06
`define ZCB_OP_GT_GROUP 6'h07
`define ZCB_OP_EQ_GROUP 6'h08
`define ZCB_OP_COP0 6'h10
`define ZCB_OP_COP1 6'h11
`define ZCB_OP_COP2 6'h12
`define ZCB_OP_LIKELY_LO 6'h14
`define ZCB_OP_LIKELY_HI 6'h17
`define ZCB_OP_NE_GROUP 6'h18
`define ZCB_OP_LONG_BR 6'h32
`define ZCB_OP_ZERO_EQ 6'h36
`define ZCB_OP_LONG_CALL 6'h3A
`define ZCB_OP_ZERO_NE 6'h3E

// Secondary codes
`define ZCB_RT_DELAYED_GE 5'h11
`define ZCB_RT_LIKELY_GE 5'h13
`define ZCB_FN_JUMP_REG 6'h08
`define ZCB_FN_CALL_REG 6'h09
`define ZCB_FN_EXC_RET 6'h18
`define ZCB_FN_DBG_RET 6'h1F
`define ZCB_FN_WAIT 6'h20
`define ZCB_RS_CBR_A 5'h08
`define ZCB_RS_CBR_B 5'h09
`define ZCB_RS_CBR_C 5'h0D
`define ZCB_PAUSE_WORD 32'h00000140

// Link and address steps
`define ZCB_REG_ZERO 5'h00
`define ZCB_LINK_REG 5'h1F
`define ZCB_STEP_NEXT 32'h00000004
`define ZCB_STEP_SECOND 32'h00000008
`define ZCB_SLOT_RESET 2'h0
`define ZCB_TARGET_RESET 32'h00000000
`define ZCB_LINK_RESET 32'h00000000
`define ZCB_INDEX_RESET 5'h00

`endif

// File: design/zcb_unit.v
// Zero-compare branch-and-link decode and execute unit
`timescale 1ns/1ps
`include "zcb_consts.vh"

module zcb_unit (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Issued instruction with its operands
    input wire issue_valid,
    input wire [31:0] issue_word,
    input wire [31:0] issue_pc,
    input wire [31:0] first_source_value,
    input wire [31:0] second_source_value,
    // Architecture level select
    input wire release6_mode,
    // Branch result
    output reg result_valid,
    output reg branch_taken,
    output reg [31:0] branch_target,
    output reg slot_has_delay,
    // Link register write
    output reg link_write,
    output reg [4:0] link_index,
    output reg [31:0] link_value,
    // Slot handling
    output reg slot_nullified,
    output reg reserved_instr_fault,
    output reg issue_passed,
    output wire forbidden_slot_open
);

    // Slot states for the instruction after a branch
    localparam SLOT_NONE = 2'h0;
    localparam SLOT_FORBID = 2'h1;
    localparam SLOT_DELAY = 2'h2;
    localparam SLOT_NULLIFY = 2'h3;

    // Instruction fields
    wire [5:0] opcode;
    wire [4:0] first_source_field;
    wire [4:0] second_source_field;
    wire [15:0] offset_field;
    wire [5:0] funct_field;

    // Slice the fields out of the issued word
    assign opcode = issue_word[`ZCB_OP_HI:`ZCB_OP_LO];
    assign first_source_field = issue_word[`ZCB_RS_HI:`ZCB_RS_LO];
    assign second_source_field = issue_word[`ZCB_RT_HI:`ZCB_RT_LO];
    assign offset_field = issue_word[`ZCB_IMM_HI:`ZCB_IMM_LO];
    assign funct_field = issue_word[`ZCB_FN_HI:`ZCB_FN_LO];

    // Register field relations
    wire rs_zero;
    wire rt_zero;
    wire fields_equal;

    // Zero register tests and field match
    assign rs_zero = (first_source_field == `ZCB_REG_ZERO);
    assign rt_zero = (second_source_field == `ZCB_REG_ZERO);
    assign fields_equal = (first_source_field == second_source_field);

    // Decoded branch-and-link forms
    reg compact_link_if_le_zero;
    reg compact_link_if_ge_zero;
    reg compact_link_if_gt_zero;
    reg compact_link_if_lt_zero;
    reg compact_link_if_eq_zero;
    reg compact_link_if_ne_zero;
    reg likely_link_if_ge_zero;
    reg delayed_link_if_ge_zero;

    // Opcode and register fields together pick the form
    always @* begin
        compact_link_if_le_zero = 1'b0;
        compact_link_if_ge_zero = 1'b0;
        compact_link_if_gt_zero = 1'b0;
        compact_link_if_lt_zero = 1'b0;
        compact_link_if_eq_zero = 1'b0;
        compact_link_if_ne_zero = 1'b0;
        likely_link_if_ge_zero = 1'b0;
        delayed_link_if_ge_zero = 1'b0;
        case (opcode)
            // Less-or-equal group: two link forms share it
            `ZCB_OP_LE_GROUP: begin
                // Zero second field stays the legacy branch
                compact_link_if_le_zero = release6_mode && rs_zero && !rt_zero;
                compact_link_if_ge_zero = release6_mode && fields_equal && !rs_zero;
            end
            // Greater-than group: the other two signed forms
            `ZCB_OP_GT_GROUP: begin
                // Zero second field stays the legacy branch
                compact_link_if_gt_zero = release6_mode && rs_zero && !rt_zero;
                compact_link_if_lt_zero = release6_mode && fields_equal && !rs_zero;
            end
            // Equal group: first field must be zero
            `ZCB_OP_EQ_GROUP: begin
                // Without release 6 this is the old add immediate
                compact_link_if_eq_zero = release6_mode && rs_zero && !rt_zero;
            end
            // Not-equal group: first field must be zero
            `ZCB_OP_NE_GROUP: begin
                // Without release 6 this is the old wide add immediate
                compact_link_if_ne_zero = release6_mode && rs_zero && !rt_zero;
            end
            // Register-immediate group: likely and delayed links
            `ZCB_OP_REGIMM: begin
                likely_link_if_ge_zero = !release6_mode &&
                    (second_source_field == `ZCB_RT_LIKELY_GE);
                // Release 6 keeps only the register zero call
                delayed_link_if_ge_zero = (second_source_field == `ZCB_RT_DELAYED_GE) &&
                    (!release6_mode || rs_zero);
            end
            // Any other opcode is no link form
            default: begin
                compact_link_if_le_zero = 1'b0;
            end
        endcase
    end

    // Form groups
    wire is_compact;
    wire is_our_branch;

    // Compact set and the full set of link forms
    assign is_compact = compact_link_if_le_zero | compact_link_if_ge_zero |
        compact_link_if_gt_zero | compact_link_if_lt_zero |
        compact_link_if_eq_zero | compact_link_if_ne_zero;
    assign is_our_branch = is_compact | likely_link_if_ge_zero | delayed_link_if_ge_zero;

    // Control transfer instruction detection
    reg control_transfer_instr;

    always @* begin
        control_transfer_instr = 1'b0;
        case (opcode)
            // Register jumps and the pause word
            `ZCB_OP_SPECIAL: begin
                control_transfer_instr = (funct_field == `ZCB_FN_JUMP_REG) ||
                    (funct_field == `ZCB_FN_CALL_REG) ||
                    (issue_word == `ZCB_PAUSE_WORD);
            end
            // Register-immediate branches and links
            `ZCB_OP_REGIMM: begin
                // Branch codes, link-without-branch among them
                control_transfer_instr = (second_source_field[3:2] == 2'b00);
            end
            // Opcodes that are branches or jumps in every mode
            `ZCB_OP_JUMP, `ZCB_OP_ABS_CALL, `ZCB_OP_BR_EQ, `ZCB_OP_BR_NE,
            `ZCB_OP_LE_GROUP, `ZCB_OP_GT_GROUP, `ZCB_OP_LONG_BR,
            `ZCB_OP_LONG_CALL, `ZCB_OP_ZERO_EQ, `ZCB_OP_ZERO_NE: begin
                control_transfer_instr = 1'b1;
            end
            // Link groups that were immediates before release 6
            `ZCB_OP_EQ_GROUP, `ZCB_OP_NE_GROUP: begin
                // Branches only once the old immediates are gone
                control_transfer_instr = release6_mode;
            end
            // Coprocessor zero returns and wait
            `ZCB_OP_COP0: begin
                // Returns and wait; no-clear return shares the code
                control_transfer_instr = issue_word[`ZCB_CO_BIT] &&
                    ((funct_field == `ZCB_FN_EXC_RET) ||
                    (funct_field == `ZCB_FN_DBG_RET) ||
                    (funct_field == `ZCB_FN_WAIT));
            end
            // Coprocessor condition branches
            `ZCB_OP_COP1, `ZCB_OP_COP2: begin
                control_transfer_instr = (first_source_field == `ZCB_RS_CBR_A) ||
                    (first_source_field == `ZCB_RS_CBR_B) ||
                    (first_source_field == `ZCB_RS_CBR_C);
            end
            // Old likely branches sit in one opcode range
            default: begin
                control_transfer_instr = (opcode >= `ZCB_OP_LIKELY_LO) &&
                    (opcode <= `ZCB_OP_LIKELY_HI);
            end
        endcase
    end

    // Tested value: second field for compact, first for delay forms
    wire [31:0] tested_value;
    wire tested_negative;
    wire tested_zero;

    // Pick the operand, then its sign and zero
    assign tested_value = is_compact ? second_source_value : first_source_value;
    assign tested_negative = tested_value[`ZCB_SIGN_BIT];
    assign tested_zero = (tested_value == 32'h00000000);

    // Condition per decoded form
    reg condition_met;

    always @* begin
        condition_met = 1'b0;
        if (compact_link_if_lt_zero) begin
            // Signed forms use the sign bit and the zero test
            condition_met = tested_negative;
        end else if (compact_link_if_le_zero) begin
            condition_met = tested_negative || tested_zero;
        end else if (compact_link_if_ge_zero) begin
            condition_met = !tested_negative;
        end else if (compact_link_if_gt_zero) begin
            condition_met = !tested_negative && !tested_zero;
        end else if (compact_link_if_eq_zero) begin
            // Equality forms ignore the sign
            condition_met = tested_zero;
        end else if (compact_link_if_ne_zero) begin
            condition_met = !tested_zero;
        end else if (likely_link_if_ge_zero) begin
            // Likely form looks at the first field's sign
            condition_met = !tested_negative;
        end else if (delayed_link_if_ge_zero) begin
            // Register zero form is an unconditional call
            condition_met = rs_zero || !tested_negative;
        end
    end

    // Target and link arithmetic
    wire [31:0] next_address;
    wire [31:0] displacement;
    wire [31:0] computed_target;
    wire [31:0] computed_link;
    wire [31:0] second_address;

    // Both return candidates and the target
    assign next_address = issue_pc + `ZCB_STEP_NEXT;
    assign second_address = issue_pc + `ZCB_STEP_SECOND;
    assign displacement = {{14{offset_field[15]}}, offset_field, 2'b00};
    assign computed_target = next_address + displacement;
    // Compact returns after the branch, delayed forms after the slot
    assign computed_link = is_compact ? next_address : second_address;

    // Slot state
    reg [1:0] slot_state;
    reg [1:0] next_slot_state;
    // Next values of the outcome pulses
    reg next_result_valid;
    reg next_slot_nullified;
    reg next_fault;
    reg next_passed;

    // Open while an untaken compact branch waits for its slot
    assign forbidden_slot_open = (slot_state == SLOT_FORBID);

    // Next slot state and per-instruction outcome
    always @* begin
        next_slot_state = slot_state;
        next_result_valid = 1'b0;
        next_slot_nullified = 1'b0;
        next_fault = 1'b0;
        next_passed = 1'b0;
        if (issue_valid) begin
            next_slot_state = SLOT_NONE;
            case (slot_state)
                // Taken compact or untaken likely drops the slot
                SLOT_NULLIFY: begin
                    next_slot_nullified = 1'b1;
                end
                // Forbidden slot after an untaken compact branch
                SLOT_FORBID: begin
                    if (control_transfer_instr) begin
                        next_fault = 1'b1;
                    end else begin
                        // Ordinary instruction runs in the slot
                        next_passed = 1'b1;
                    end
                end
                // Delay slot after a delayed or taken likely form
                SLOT_DELAY: begin
                    // Release 6 faults transfers here too
                    if (control_transfer_instr && release6_mode) begin
                        next_fault = 1'b1;
                    end else begin
                        next_passed = 1'b1;
                    end
                end
                // No slot pending: decode a fresh instruction
                default: begin
                    if (is_our_branch) begin
                        next_result_valid = 1'b1;
                        if (is_compact) begin
                            // Taken skips the slot; untaken opens it
                            next_slot_state = condition_met ? SLOT_NULLIFY : SLOT_FORBID;
                        end else if (likely_link_if_ge_zero) begin
                            next_slot_state = condition_met ? SLOT_DELAY : SLOT_NULLIFY;
                        end else begin
                            // Delayed form always runs its slot
                            next_slot_state = SLOT_DELAY;
                        end
                    end else begin
                        // Not a link form: it runs as usual
                        next_passed = 1'b1;
                    end
                end
            endcase
        end
    end

    // Slot state register and pulses
    always @(posedge ref_clk) begin
        if (reset) begin
            // No slot pending and no pulses after reset
            slot_state <= `ZCB_SLOT_RESET;
            result_valid <= 1'b0;
            slot_nullified <= 1'b0;
            reserved_instr_fault <= 1'b0;
            issue_passed <= 1'b0;
        end else begin
            slot_state <= next_slot_state;
            result_valid <= next_result_valid;
            slot_nullified <= next_slot_nullified;
            reserved_instr_fault <= next_fault;
            issue_passed <= next_passed;
        end
    end

    // Branch result and link write registers
    always @(posedge ref_clk) begin
        if (reset) begin
            // Result and link outputs start cleared
            branch_taken <= 1'b0;
            branch_target <= `ZCB_TARGET_RESET;
            slot_has_delay <= 1'b0;
            link_write <= 1'b0;
            link_index <= `ZCB_INDEX_RESET;
            link_value <= `ZCB_LINK_RESET;
        end else begin
            // Link written for every link form, taken or not
            link_write <= next_result_valid;
            if (next_result_valid) begin
                // Capture the result; all but branch_taken hold until the next one
                branch_taken <= condition_met;
                branch_target <= computed_target;
                slot_has_delay <= !is_compact;
                link_index <= `ZCB_LINK_REG;
                link_value <= computed_link;
            end else begin
                // Taken only counts beside result_valid
                branch_taken <= 1'b0;
            end
        end
    end

endmodule // zcb_unit

// File: verif/zcb_unit_checker.sv
// Assertions for the zero-compare branch-and-link unit
`timescale 1ns/1ps
module zcb_unit_checker (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Issue side
    input wire issue_valid,
    input wire [31:0] issue_word,
    input wire [31:0] issue_pc,
    input wire [31:0] first_source_value,
    // Results
    input wire result_valid,
    input wire branch_taken,
    input wire [31:0] branch_target,
    input wire slot_has_delay,
    input wire link_write,
    input wire [4:0] link_index,
    input wire [31:0] link_value,
    input wire slot_nullified,
    input wire reserved_instr_fault,
    input wire issue_passed,
    input wire forbidden_slot_open
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Decoded helpers for the previous issue
    wire [3:0] answers = {result_valid, slot_nullified, reserved_instr_fault, issue_passed};
    wire [31:0] disp = {{14{issue_word[15]}}, issue_word[15:0], 2'b00};
    wire regimm = issue_word[31:26] == 6'h01;
    wire likely = regimm && issue_word[20:16] == 5'h13;
    wire neg = first_source_value[31];
    chk_one_answer: assert property (issue_valid |=> $onehot(answers))
        else $error("not exactly one answer");
    chk_idle_quiet: assert property (!issue_valid |=> answers == 4'h0)
        else $error("answer without issue");
    chk_link_pulse: assert property (link_write == result_valid)
        else $error("link write mismatch");
    chk_link_index: assert property (result_valid |-> link_index == 5'h1F)
        else $error("link index wrong");
    chk_compact_link: assert property (result_valid && !slot_has_delay |-> link_value == $past(issue_pc) + 32'h4)
        else $error("compact link wrong");
    chk_delay_link: assert property (result_valid && slot_has_delay |-> link_value == $past(issue_pc) + 32'h8)
        else $error("delayed link wrong");
    chk_target_calc: assert property (result_valid |-> branch_target == $past(issue_pc) + 32'h4 + $past(disp))
        else $error("target wrong");
    chk_taken_skip: assert property (result_valid && branch_taken && !slot_has_delay && issue_valid |=> slot_nullified)
        else $error("taken slot not dropped");
    chk_open_slot: assert property (result_valid && !slot_has_delay |-> forbidden_slot_open == !branch_taken)
        else $error("forbidden slot state wrong");
    chk_likely_drop: assert property (result_valid && !branch_taken && $past(likely) && issue_valid |=> slot_nullified)
        else $error("likely slot not dropped");
    chk_sign_test: assert property (result_valid && $past(regimm) |-> branch_taken == !$past(neg))
        else $error("sign test wrong");
    // Main scenarios reached
    cov_taken: cover property (result_valid && branch_taken);
    cov_fault: cover property (reserved_instr_fault);
    cov_drop: cover property (slot_nullified);
endmodule // zcb_unit_checker

bind zcb_unit zcb_unit_checker u_chk (.ref_clk, .reset, .issue_valid, .issue_word, .issue_pc, .first_source_value,
    .result_valid, .branch_taken, .branch_target, .slot_has_delay, .link_write, .link_index, .link_value,
    .slot_nullified, .reserved_instr_fault, .issue_passed, .forbidden_slot_open);

// File: verif/zcb_core_model.sv
// Register file model standing in for the core
`timescale 1ns/1ps
module zcb_core_model (
    // Clock
    input wire ref_clk,
    // Loader from the bench
    input wire load_en,
    input wire [4:0] load_index,
    input wire [31:0] load_data,
    // Issue word and link write
    input wire [31:0] issue_word,
    input wire link_write,
    input wire [4:0] link_index,
    input wire [31:0] link_value,
    // Operand values
    output wire [31:0] first_source_value,
    output wire [31:0] second_source_value
);
    reg [31:0] regs [0:31];
    // Register zero always reads zero
    assign first_source_value = issue_word[25:21] == 5'h00 ? 32'h0 : regs[issue_word[25:21]];
    assign second_source_value = issue_word[20:16] == 5'h00 ? 32'h0 : regs[issue_word[20:16]];
    // Link writes land like any other result
    always @(posedge ref_clk) begin
        if (link_write) regs[link_index] <= link_value;
        if (load_en) regs[load_index] <= load_data;
    end
endmodule // zcb_core_model

// File: verif/tb_zcb_unit.sv
// Self-checking bench for the zero-compare branch-and-link unit
`timescale 1ns/1ps
module tb_zcb_unit;
    reg ref_clk, reset, issue_valid, release6_mode, load_en;
    reg [31:0] issue_word, issue_pc, load_data;
    reg [4:0] load_index;
    wire [31:0] first_source_value, second_source_value, branch_target, link_value;
    wire [4:0] link_index;
    wire result_valid, branch_taken, slot_has_delay, link_write;
    wire slot_nullified, reserved_instr_fault, issue_passed, forbidden_slot_open;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer k, j;
    localparam [31:0] PC = 32'h00001000;
    localparam [15:0] OFS = 16'hFFFE;
    localparam [31:0] TGT = 32'h00000FFC; // Next address minus eight
    reg [31:0] ctis [0:8];
    reg [31:0] vals [0:2];
    zcb_unit DUT (.ref_clk, .reset, .issue_valid, .issue_word, .issue_pc, .first_source_value,
        .second_source_value, .release6_mode, .result_valid, .branch_taken, .branch_target, .slot_has_delay,
        .link_write, .link_index, .link_value, .slot_nullified, .reserved_instr_fault, .issue_passed,
        .forbidden_slot_open);
    zcb_core_model M (.ref_clk, .load_en, .load_index, .load_data, .issue_word, .link_write, .link_index,
        .link_value, .first_source_value, .second_source_value);
    // Free-running clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    task check(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task drive(input [31:0] w, input [31:0] pc, input v);
        begin
            @(posedge ref_clk);
            #1;
            issue_valid = v;
            issue_word = w;
            issue_pc = pc;
        end
    endtask
    // Loads register 5; never register 31 as a source
    task setr(input [31:0] d);
        begin
            drive(0, 0, 0);
            load_en = 1;
            load_index = 5;
            load_data = d;
            @(posedge ref_clk);
            #1;
            load_en = 0;
        end
    endtask
    task result(input tk, input dl);
        begin
            check("result_valid", 1, result_valid);
            check("branch_taken", tk, branch_taken);
            check("slot_has_delay", dl, slot_has_delay);
            check("link_write", 1, link_write);
            check("link_value", dl ? PC + 8 : PC + 4, link_value);
            check("link_index", 5'h1F, link_index);
            check("branch_target", TGT, branch_target);
        end
    endtask
    // Outcome of the slot instruction: nullified, fault, passed
    task outcome(input [2:0] e);
        begin
            drive(0, 0, 0);
            check("slot_outcome", e, {slot_nullified, reserved_instr_fault, issue_passed});
        end
    endtask
    function ex(input integer k, input [31:0] v);
        case (k)
            0: ex = v[31] || v == 0;
            1: ex = !v[31];
            2: ex = !v[31] && v != 0;
            3: ex = v[31];
            4: ex = v == 0;
            default: ex = v != 0;
        endcase
    endfunction
    function [31:0] cbr(input integer k);
        cbr = {k < 2 ? 6'h06 : k < 4 ? 6'h07 : k == 4 ? 6'h08 : 6'h18, k == 1 || k == 3 ? 5'd5 : 5'd0, 5'd5, OFS};
    endfunction
    // All six compact forms over zero, positive and negative
    task t_compact;
        for (k = 0; k < 6; k = k + 1) begin
            for (j = 0; j < 3; j = j + 1) begin
                setr(vals[j]);
                drive(cbr(k), PC, 1);
                drive(0, PC + 4, 1);
                result(ex(k, vals[j]), 0);
                check("forbidden_slot_open", !ex(k, vals[j]), forbidden_slot_open);
                outcome(ex(k, vals[j]) ? 3'h4 : 3'h1);
            end
        end
    endtask
    // Transfers in the forbidden slot fault only when not taken
    task t_forbidden;
        for (j = 0; j < 2; j = j + 1) begin
            setr(j ? 32'h0 : 32'h7);
            for (k = 0; k < 9; k = k + 1) begin
                drive(cbr(4), PC, 1);
                drive(ctis[k], PC + 4, 1);
                outcome(j ? 3'h4 : 3'h2);
            end
        end
    endtask
    task t_likely;
        begin
            release6_mode = 0;
            for (j = 0; j < 2; j = j + 1) begin
                setr(j ? 32'h80000000 : 32'h3);
                drive({6'h01, 5'd5, 5'h13, OFS}, PC, 1);
                drive(0, PC + 4, 1);
                result(!j, 1);
                outcome(j ? 3'h4 : 3'h1);
            end
            release6_mode = 1;
            drive({6'h01, 5'd5, 5'h13, OFS}, PC, 1);
            outcome(3'h1);
        end
    endtask
    // Register-zero delayed link is a call; a jump in its slot faults
    task t_call;
        begin
            drive({6'h01, 5'd0, 5'h11, OFS}, PC, 1);
            drive(ctis[0], PC + 4, 1);
            result(1, 1);
            outcome(3'h2);
            // Release 6 drops the conditional delayed link
            setr(32'h80000000);
            drive({6'h01, 5'd5, 5'h11, OFS}, PC, 1);
            outcome(3'h1);
            // Before release 6 it tests the sign and runs its slot
            release6_mode = 0;
            drive({6'h01, 5'd5, 5'h11, OFS}, PC, 1);
            drive(0, PC + 4, 1);
            result(0, 1);
            outcome(3'h1);
            // Equal group is still the old immediate here
            drive(cbr(4), PC, 1);
            outcome(3'h1);
            release6_mode = 1;
        end
    endtask
    // Reset in mid-branch clears results and slot state
    task t_reset;
        begin
            drive(cbr(4), PC, 1);
            drive(0, 0, 0);
            reset = 1;
            drive(0, 0, 0);
            reset = 0;
            check("link_value", 0, link_value);
            check("result_valid", 0, result_valid);
            check("forbidden_slot_open", 0, forbidden_slot_open);
            outcome(3'h0);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // Watchdog on the whole run
    initial begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    // Main sequence
    initial begin
        reset = 1;
        issue_valid = 0;
        issue_word = 0;
        issue_pc = 0;
        release6_mode = 1;
        load_en = 0;
        load_index = 0;
        load_data = 0;
        vals[0] = 32'h0;
        vals[1] = 32'h5;
        vals[2] = 32'h80000000;
        ctis[0] = 32'h08000040;
        ctis[1] = 32'h00A00008;
        ctis[2] = 32'h00000140;
        ctis[3] = 32'h42000018;
        ctis[4] = 32'h4200001F;
        ctis[5] = 32'h42000020;
        ctis[6] = 32'h04110004;
        ctis[7] = 32'h04100000;
        ctis[8] = 32'h10000003;
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 0;
        t_compact;
        t_forbidden;
        t_likely;
        t_call;
        t_reset;
        test_done;
    end
endmodule // tb_zcb_unit
